//--- hw/sched_pkg.sv
// Shared constants for the request scheduler
package sched_pkg;
  // Timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000 * TICK_MS;
  localparam logic [14:0] TIMEOUT_STEP_MS = 15'd100;
  localparam logic [7:0] TIMEOUT_MIN_STEPS = 8'd3;
  localparam logic [7:0] TIMEOUT_RST_STEPS = 8'd10;
  localparam logic [12:0] GAP_MAX_MS = 13'd5000;
  localparam logic [12:0] GAP_RST_MS = 13'd0;
  localparam logic [1:0] RETRIES = 2'd2;
  // Commands
  localparam logic [31:0] CMD_RD_WORD = 32'h04010000;
  localparam logic [31:0] CMD_RD_BIT = 32'h04010001;
  localparam logic [31:0] CMD_WR_WORD = 32'h14010000;
  localparam logic [31:0] CMD_WR_BIT = 32'h14010001;
  // Remote device types
  localparam logic [2:0] DEV_IN = 3'h0;
  localparam logic [2:0] DEV_OUT = 3'h1;
  localparam logic [2:0] DEV_RELAY = 3'h2;
  localparam logic [2:0] DEV_SPECIAL_RELAY = 3'h3;
  localparam logic [2:0] DEV_DREG = 3'h4;
  localparam logic [2:0] DEV_SPECIAL_REG = 3'h5;
  localparam logic [31:0] NUM_MAX = 32'h00ffffff;
  localparam logic [9:0] PTS_MIN = 10'h001;
  localparam logic [9:0] PTS_MAX = 10'h200;
  // Status codes
  localparam logic [7:0] ERR_OK = 8'h00;
  localparam logic [15:0] END_OK = 16'h0000;
  localparam logic [7:0] ERR_TIMEOUT = 8'h01;
  localparam logic [7:0] ERR_CONFIG = 8'h02;
  localparam logic [7:0] ERR_ABNORMAL = 8'h03;
  localparam logic [15:0] END_TIMEOUT = 16'hffff;
  localparam logic [15:0] END_CONFIG = 16'hfffe;
  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TIMEOUT = 8'h04;
  localparam logic [7:0] OFS_GAP = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0c;
  localparam logic [7:0] OFS_TBL_IDX = 8'h10;
  localparam logic [7:0] OFS_TBL_CMD = 8'h14;
  localparam logic [7:0] OFS_TBL_DEV = 8'h18;
  localparam logic [7:0] OFS_TBL_NUM = 8'h1c;
  localparam logic [7:0] OFS_TBL_PTS = 8'h20;
  localparam logic [7:0] OFS_EXEC = 8'h24;
  localparam logic [7:0] OFS_HOST = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2c;
  localparam logic [7:0] OFS_STATE = 8'h30;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h34;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h38;
  // Control bits
  localparam int unsigned CTL_RUN = 0;
  localparam int unsigned CTL_EXEC_EN = 1;
  localparam int unsigned CTL_SYNC_EN = 2;
  localparam int unsigned CTL_STAT_EN = 3;
  localparam int unsigned CTL_FAIL_ONLY = 4;
  localparam int unsigned CTL_SINGLE = 5;
  localparam logic [5:0] CTRL_RST = 6'h00;
  // Interrupt events
  localparam int unsigned EV_DONE = 0;
  localparam int unsigned EV_FAIL = 1;
  localparam int unsigned EV_CONFIG = 2;
endpackage

//--- hw/ms_tick.sv
// Millisecond enable pulse divided from the system clock
module ms_tick import sched_pkg::*; #(
  parameter int unsigned CYCLES = CYC_PER_MS
) (
  input wire logic mclk,
  input wire logic nrst,
  output logic tick
);
  logic [31:0] cnt_reg;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_reg <= 32'h0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (cnt_reg == 32'(CYCLES - 1));
      cnt_reg <= (cnt_reg == 32'(CYCLES - 1)) ? 32'h0 : cnt_reg + 32'h1;
    end
  end
endmodule

//--- hw/target_check.sv
// Command, device type, number and point count validity
module target_check import sched_pkg::*; (
  input wire logic [31:0] cmd,
  input wire logic [2:0] dev,
  input wire logic [31:0] num,
  input wire logic [9:0] pts,
  output logic ok
);
  logic dev_ok;

  always_comb
  begin
    dev_ok = 1'b0;
    case (cmd)
      CMD_RD_WORD: dev_ok = (dev <= DEV_SPECIAL_REG);
      CMD_RD_BIT: dev_ok = (dev <= DEV_SPECIAL_RELAY);
      CMD_WR_WORD: dev_ok = (dev == DEV_DREG);
      CMD_WR_BIT: dev_ok = (dev <= DEV_RELAY);
      default: dev_ok = 1'b0;
    endcase
  end

  // Every device type shares the 24-bit number space
  assign ok = dev_ok && (num <= NUM_MAX) && (pts >= PTS_MIN) && (pts <= PTS_MAX);
endmodule

//--- hw/plc_request_scheduler.sv
// Request scheduler: table walk, gating, timeout, retry and status
// Operation
// - word read accepts all six device types
// - bit read rejects both register kinds
// - word write targets data registers only
// - bit write targets inputs, outputs, relays
// - input/output numbers hex zero to FFFFFF
// - other numbers decimal up to 16777215
// - response timeout 300 to 25500 ms
// - gap of 0 to 5000 ms between requests
// - ascending order, repeating, started at scan end
// - link traffic independent of user program
// - run only if flag and online allow
// - completion when execution flag auto-cleared
// - completion when status word written
// - advance only after current request completes
// - success stores zero codes unless failure-only
// - two retries, then error, clear, gap
// - reuse connection for same host, else reopen
// - point count from 1 to 512
module plc_request_scheduler import sched_pkg::*; #(
  parameter int unsigned CYCLES_PER_MS = CYC_PER_MS
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic scan_end,
  output logic link_open,
  output logic link_close,
  output logic [7:0] link_host,
  output logic req_valid,
  input wire logic req_ready,
  output logic [31:0] req_cmd,
  output logic [2:0] req_dev,
  output logic [23:0] req_num,
  output logic [9:0] req_pts,
  input wire logic resp_valid,
  input wire logic resp_err,
  input wire logic [15:0] resp_end,
  output logic status_we,
  output logic [8:0] status_addr,
  output logic [7:0] status_err,
  output logic [15:0] status_end,
  output logic irq
);
  typedef enum logic [2:0] {
    st_idle, st_eval, st_connect, st_send, st_wait, st_finish, st_gap
  } state_e;

  state_e state_reg;
  logic [5:0] ctrl_reg;
  logic [7:0] timeout_reg, count_reg, tbl_idx_reg, cur_reg, cur_next, to_steps, a_reg, host_sel;
  logic [12:0] gap_reg;
  logic [14:0] ms_reg, to_limit;
  logic [2:0] irq_stat_reg, irq_mask_reg, ev;
  logic [1:0] retry_reg;
  logic [31:0] tbl_cmd [256], tbl_num [256];
  logic [2:0] tbl_dev [256];
  logic [7:0] tbl_host [256];
  logic [9:0] tbl_pts [256];
  logic [255:0] exec_flag, host_online, host_ping;
  logic tick, entry_ok, runnable, timed_out, gap_done, stat_store, connected_reg;
  logic wr_reg, rd_reg, rd_ok_reg, acc, we;

  ms_tick #(.CYCLES(CYCLES_PER_MS)) u_tick (.mclk(mclk), .nrst(nrst), .tick(tick));

  target_check u_check (.cmd(tbl_cmd[cur_reg]), .dev(tbl_dev[cur_reg]), .num(tbl_num[cur_reg]),
    .pts(tbl_pts[cur_reg]), .ok(entry_ok));

  // AHB-Lite slave: zero-wait writes, one wait state on reads
  assign acc = hsel && htrans[1] && hready;
  assign we = wr_reg;
  assign hreadyout = !(rd_reg && !rd_ok_reg);
  assign hresp = 1'b0;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      a_reg <= 8'h00;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      rd_ok_reg <= 1'b0;
    end
    else
    begin
      rd_ok_reg <= rd_reg && !rd_ok_reg;
      if (hready)
      begin
        wr_reg <= acc && hwrite;
        rd_reg <= acc && !hwrite;
        if (acc)
          a_reg <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      hrdata <= 32'h0;
    else if (rd_reg && !rd_ok_reg)
    begin
      case (a_reg)
        OFS_CTRL: hrdata <= {26'h0, ctrl_reg};
        OFS_TIMEOUT: hrdata <= {24'h0, timeout_reg};
        OFS_GAP: hrdata <= {19'h0, gap_reg};
        OFS_COUNT: hrdata <= {24'h0, count_reg};
        OFS_TBL_IDX: hrdata <= {24'h0, tbl_idx_reg};
        OFS_TBL_CMD: hrdata <= tbl_cmd[tbl_idx_reg];
        OFS_TBL_DEV: hrdata <= {16'h0, tbl_host[tbl_idx_reg], 5'h0, tbl_dev[tbl_idx_reg]};
        OFS_TBL_NUM: hrdata <= tbl_num[tbl_idx_reg];
        OFS_TBL_PTS: hrdata <= {22'h0, tbl_pts[tbl_idx_reg]};
        OFS_EXEC: hrdata <= {31'h0, exec_flag[tbl_idx_reg]};
        OFS_STATUS: hrdata <= {cur_reg, status_err, status_end};
        OFS_STATE: hrdata <= {10'h0, retry_reg, connected_reg, link_host, cur_reg, state_reg};
        OFS_IRQ_STAT: hrdata <= {29'h0, irq_stat_reg};
        OFS_IRQ_MASK: hrdata <= {29'h0, irq_mask_reg};
        default: hrdata <= 32'h0;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_reg <= CTRL_RST;
      timeout_reg <= TIMEOUT_RST_STEPS;
      gap_reg <= GAP_RST_MS;
      count_reg <= 8'h00;
      tbl_idx_reg <= 8'h00;
      irq_mask_reg <= 3'h0;
    end
    else if (we)
    begin
      case (a_reg)
        OFS_CTRL: ctrl_reg <= hwdata[5:0];
        OFS_TIMEOUT: timeout_reg <= hwdata[7:0];
        OFS_GAP: gap_reg <= (hwdata[12:0] > GAP_MAX_MS) ? GAP_MAX_MS : hwdata[12:0];
        OFS_COUNT: count_reg <= hwdata[7:0];
        OFS_TBL_IDX: tbl_idx_reg <= hwdata[7:0];
        OFS_IRQ_MASK: irq_mask_reg <= hwdata[2:0];
        default: ;
      endcase
    end
  end

  // Request table, written through the selected index
  always_ff @(posedge mclk)
  begin
    if (we && a_reg == OFS_TBL_CMD)
      tbl_cmd[tbl_idx_reg] <= hwdata;
    if (we && a_reg == OFS_TBL_NUM)
      tbl_num[tbl_idx_reg] <= hwdata;
    if (we && a_reg == OFS_TBL_PTS)
      tbl_pts[tbl_idx_reg] <= hwdata[9:0];
    if (we && a_reg == OFS_TBL_DEV)
    begin
      tbl_dev[tbl_idx_reg] <= hwdata[2:0];
      tbl_host[tbl_idx_reg] <= hwdata[15:8];
    end
  end

  // Host online and ping-target bits
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      host_online <= '0;
      host_ping <= '0;
    end
    else if (we && a_reg == OFS_HOST)
    begin
      host_online[hwdata[7:0]] <= hwdata[8];
      host_ping[hwdata[7:0]] <= hwdata[9];
    end
  end

  // Execution flags: software write takes precedence over auto-clear
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      exec_flag <= '0;
    else
    begin
      if (state_reg == st_finish && ctrl_reg[CTL_EXEC_EN])
        exec_flag[cur_reg] <= 1'b0;
      if (we && a_reg == OFS_EXEC)
        exec_flag[hwdata[7:0]] <= hwdata[8];
    end
  end

  assign host_sel = tbl_host[cur_reg];
  assign runnable = (!ctrl_reg[CTL_EXEC_EN] || exec_flag[cur_reg]) && (!ctrl_reg[CTL_SYNC_EN] ||
                    !host_ping[host_sel] || host_online[host_sel]);
  assign cur_next = (cur_reg + 8'h01 >= count_reg) ? 8'h00 : cur_reg + 8'h01;
  assign to_steps = (timeout_reg < TIMEOUT_MIN_STEPS) ? TIMEOUT_MIN_STEPS : timeout_reg;
  assign to_limit = 15'(to_steps) * TIMEOUT_STEP_MS;
  assign timed_out = tick && (ms_reg >= to_limit);
  assign gap_done = (gap_reg == 13'h0) || (ms_reg > 15'(gap_reg));
  // Millisecond counter, restarted on each dispatch and at completion
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      ms_reg <= 15'h0;
    else if (state_reg == st_send || state_reg == st_finish)
      ms_reg <= 15'h0;
    else if (tick && (state_reg == st_wait || state_reg == st_gap) && ms_reg != 15'h7fff)
      ms_reg <= ms_reg + 15'h1;
  end

  // Sequencer; runs on its own, decoupled from the user program
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= st_idle;
      cur_reg <= 8'h00;
      retry_reg <= 2'h0;
      connected_reg <= 1'b0;
      link_host <= 8'h00;
      req_cmd <= 32'h0;
      req_dev <= 3'h0;
      req_num <= 24'h0;
      req_pts <= 10'h0;
      status_err <= ERR_OK;
      status_end <= END_OK;
    end
    else
    begin
      case (state_reg)
        st_idle:
          if (ctrl_reg[CTL_RUN] && scan_end && count_reg != 8'h00)
            state_reg <= st_eval;
        st_eval:
        begin
          retry_reg <= 2'h0;
          req_cmd <= tbl_cmd[cur_reg];
          req_dev <= tbl_dev[cur_reg];
          req_num <= tbl_num[cur_reg][23:0];
          req_pts <= tbl_pts[cur_reg];
          if (!runnable)
          begin
            cur_reg <= cur_next;
            state_reg <= st_idle;
          end
          else if (!entry_ok)
          begin
            status_err <= ERR_CONFIG;
            status_end <= END_CONFIG;
            state_reg <= st_finish;
          end
          else if (connected_reg && link_host == host_sel)
            state_reg <= st_send;
          else
            state_reg <= st_connect;
        end
        st_connect:
        begin
          connected_reg <= 1'b1;
          link_host <= host_sel;
          state_reg <= st_send;
        end
        st_send:
          if (req_ready)
            state_reg <= st_wait;
        st_wait:
          if (resp_valid)
          begin
            status_err <= resp_err ? ERR_ABNORMAL : ERR_OK;
            status_end <= resp_err ? resp_end : END_OK;
            state_reg <= st_finish;
          end
          else if (timed_out && retry_reg < RETRIES)
          begin
            retry_reg <= retry_reg + 2'h1;
            state_reg <= st_send;
          end
          else if (timed_out)
          begin
            status_err <= ERR_TIMEOUT;
            status_end <= END_TIMEOUT;
            state_reg <= st_finish;
          end
        st_finish:
          state_reg <= st_gap;
        st_gap:
          if (gap_done)
          begin
            cur_reg <= cur_next;
            state_reg <= st_idle;
          end
        default:
          state_reg <= st_idle;
      endcase
    end
  end
  assign link_open = (state_reg == st_connect);
  assign link_close = (state_reg == st_connect) && connected_reg;
  assign req_valid = (state_reg == st_send);
  assign stat_store = ctrl_reg[CTL_STAT_EN] &&
                      (status_err != ERR_OK || !ctrl_reg[CTL_FAIL_ONLY]);
  assign status_we = (state_reg == st_finish) && stat_store;
  assign status_addr = ctrl_reg[CTL_SINGLE] ? 9'h000 : {cur_reg, 1'b0};
  // Sticky events, set wins over write-one-to-clear
  assign ev[EV_DONE] = (state_reg == st_finish) && status_err == ERR_OK;
  assign ev[EV_FAIL] = (state_reg == st_finish) && status_err != ERR_OK;
  assign ev[EV_CONFIG] = (state_reg == st_finish) && status_err == ERR_CONFIG;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      irq_stat_reg <= 3'h0;
    else
      irq_stat_reg <= (irq_stat_reg & ~((we && a_reg == OFS_IRQ_STAT) ? hwdata[2:0] : 3'h0))
                      | ev;
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);
  sequence seq_timeout;
    state_reg == st_wait && !resp_valid && timed_out;
  endsequence
  chk_word_write_dev: assert property (@(posedge mclk) disable iff (!nrst)
    req_valid && req_cmd == CMD_WR_WORD |-> req_dev == DEV_DREG)
    else $error("word write to non data register");
  chk_bit_read_dev: assert property (@(posedge mclk) disable iff (!nrst)
    req_valid && req_cmd == CMD_RD_BIT |-> req_dev <= DEV_SPECIAL_RELAY)
    else $error("bit read to register device");
  chk_bit_write_dev: assert property (@(posedge mclk) disable iff (!nrst)
    req_valid && req_cmd == CMD_WR_BIT |-> req_dev <= DEV_RELAY)
    else $error("bit write to special or register device");
  chk_point_range: assert property (@(posedge mclk) disable iff (!nrst)
    req_valid |-> req_pts >= PTS_MIN && req_pts <= PTS_MAX)
    else $error("point count out of range");
  chk_ok_status: assert property (@(posedge mclk) disable iff (!nrst)
    status_we && status_err == ERR_OK |-> status_end == END_OK && !ctrl_reg[CTL_FAIL_ONLY])
    else $error("bad success status store");
  chk_flag_cleared: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == st_finish && ctrl_reg[CTL_EXEC_EN] && !(we && a_reg == OFS_EXEC)
    |=> !exec_flag[$past(cur_reg)])
    else $error("execution flag not cleared");
  chk_retry_then_fail: assert property (@(posedge mclk) disable iff (!nrst)
    seq_timeout |=> (retry_reg == $past(retry_reg) + 2'h1 && state_reg == st_send) or
                    ($past(retry_reg) == RETRIES && status_err == ERR_TIMEOUT))
    else $error("timeout retry sequence broken");
  chk_advance_gap: assert property (@(posedge mclk) disable iff (!nrst)
    $changed(cur_reg) |-> $past(state_reg) == st_gap || $past(state_reg) == st_eval)
    else $error("request advanced before completion");
  chk_gate_dispatch: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == st_eval && !runnable |=> state_reg == st_idle ##1 !req_valid)
    else $error("gated request dispatched");
  chk_reopen_close: assert property (@(posedge mclk) disable iff (!nrst)
    link_open && connected_reg |-> link_close && host_sel != link_host)
    else $error("connection reopened without close");
  chk_end_scan_start: assert property (@(posedge mclk) disable iff (!nrst)
    state_reg == st_idle ##1 state_reg == st_eval |-> $past(scan_end))
    else $error("dispatch outside end of scan");
endmodule

//--- sim/remote_ctrl.sv
// Behavioural remote controller that answers scheduler requests
module remote_ctrl (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire logic [1:0] mode,
  input wire logic [3:0] lat,
  output logic req_ready,
  output logic resp_valid,
  output logic resp_err,
  output logic [15:0] resp_end
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy;
  logic [3:0] cnt;
  // Mode 0 normal, 1 silent, 2 abnormal; lat sets both accept and reply delay
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      req_ready <= 1'b0;
      resp_valid <= 1'b0;
      resp_err <= 1'b0;
      resp_end <= 16'h0000;
      busy <= 1'b0;
      cnt <= 4'h0;
    end
    else
    begin
      req_ready <= 1'b0;
      resp_valid <= 1'b0;
      // Released reply lines never hold their last value
      resp_err <= ~resp_err;
      resp_end <= ~resp_end;
      if (req_valid && !req_ready && !busy)
      begin
        cnt <= cnt + 4'h1;
        if (cnt >= lat)
        begin
          req_ready <= 1'b1;
          busy <= 1'b1;
          cnt <= 4'h0;
        end
      end
      else if (busy)
      begin
        cnt <= cnt + 4'h1;
        if (cnt >= lat)
        begin
          busy <= 1'b0;
          cnt <= 4'h0;
          resp_valid <= (mode != 2'd1);
          resp_err <= (mode == 2'd2);
          resp_end <= (mode == 2'd2) ? 16'h00c1 : 16'h0000;
        end
      end
    end
  end
endmodule

//--- sim/tb_plc_request_scheduler.sv
// Self-checking testbench for the request scheduler
module tb_plc_request_scheduler import sched_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned CPM = 10;
  typedef struct packed {logic [31:0] cmd; logic [5:0] mask; logic [31:0] num; logic [9:0] pts;} row_s;
  logic mclk, nrst, hsel, hwrite, hready, hreadyout, hresp, scan_end, irq;
  logic link_open, link_close, req_valid, req_ready, resp_valid, resp_err, status_we;
  logic [31:0] haddr, hwdata, hrdata, req_cmd, rd;
  logic [1:0] htrans, pmode;
  logic [2:0] hsize, req_dev;
  logic [7:0] link_host, status_err;
  logic [23:0] req_num;
  logic [9:0] req_pts;
  logic [15:0] resp_end, status_end;
  logic [8:0] status_addr;
  logic [3:0] plat;
  logic [31:0] cmd_q [16];
  logic [31:0] we_q [16];
  int t_req [16];
  int t_we [16];
  int cyc, n_req, n_open, n_close, n_we, mismatches, checks;
  row_s rows [7];

  assign hready = hreadyout;
  plc_request_scheduler #(.CYCLES_PER_MS(CPM)) uut (
    .mclk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
    .hresp, .hrdata, .scan_end, .link_open, .link_close, .link_host, .req_valid,
    .req_ready, .req_cmd, .req_dev, .req_num, .req_pts, .resp_valid, .resp_err,
    .resp_end, .status_we, .status_addr, .status_err, .status_end, .irq
  );
  remote_ctrl far (.mclk, .nrst, .req_valid, .mode(pmode), .lat(plat), .req_ready,
    .resp_valid, .resp_err, .resp_end);

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // End-of-scan pulse every 50 cycles
  initial
  begin
    scan_end = 1'b0;
    forever
    begin
      repeat (49) @(posedge mclk);
      scan_end <= 1'b1;
      @(posedge mclk);
      scan_end <= 1'b0;
    end
  end

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (req_valid && req_ready)
    begin
      t_req[n_req % 16] <= cyc;
      cmd_q[n_req % 16] <= req_cmd;
      n_req <= n_req + 1;
    end
    if (link_open)
      n_open <= n_open + 1;
    if (link_close)
      n_close <= n_close + 1;
    if (status_we)
    begin
      t_we[n_we % 16] <= cyc;
      we_q[n_we % 16] <= {status_addr[7:0], status_err, status_end};
      n_we <= n_we + 1;
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task test_done;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Waits for hready high at a rising edge; data sampled while settled
  task rdy(output logic [31:0] d);
    logic r;
    r = 1'b0;
    while (r !== 1'b1)
    begin
      @(negedge mclk);
      r = hreadyout;
      d = hrdata;
      @(posedge mclk);
    end
  endtask

  task addr(input logic [7:0] a, input logic w);
    logic [31:0] x;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    rdy(x);
    hsel <= 1'b0;
    htrans <= 2'b00;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    addr(a, 1'b1);
    hwdata <= d;
    rdy(x);
  endtask

  task rg(input logic [7:0] a, output logic [31:0] d);
    addr(a, 1'b0);
    rdy(d);
  endtask

  task set_ent(input logic [7:0] i, input logic [31:0] c, input logic [2:0] dv,
               input logic [7:0] h, input logic [31:0] n, input logic [9:0] p);
    wr(OFS_TBL_IDX, {24'h0, i});
    wr(OFS_TBL_CMD, c);
    wr(OFS_TBL_DEV, {16'h0, h, 5'h0, dv});
    wr(OFS_TBL_NUM, n);
    wr(OFS_TBL_PTS, {22'h0, p});
  endtask

  task wt(input bit q, input int n);
    int k;
    k = 0;
    while (((q ? n_req : n_we) < n) && k < 15000)
    begin
      @(posedge mclk);
      k++;
    end
    if (k >= 15000)
      mismatches++;
  endtask

  initial
  begin
    #2_000_000;
    mismatches++;
    test_done;
  end

  initial
  begin
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    pmode = 2'd0;
    plat = 4'h2;
    {cyc, n_req, n_open, n_close, n_we, mismatches, checks} = '0;
    rows[0] = '{CMD_RD_WORD, 6'h3f, 32'h0, 10'h001};
    rows[1] = '{CMD_RD_BIT, 6'h0f, 32'h00ffffff, 10'h200};
    rows[2] = '{CMD_WR_WORD, 6'h10, 32'h5, 10'h008};
    rows[3] = '{CMD_WR_BIT, 6'h07, 32'h0, 10'h001};
    rows[4] = '{CMD_RD_WORD, 6'h00, 32'h01000000, 10'h001};
    rows[5] = '{CMD_RD_WORD, 6'h00, 32'h0, 10'h000};
    rows[6] = '{CMD_RD_WORD, 6'h00, 32'h0, 10'h201};
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    wr(OFS_COUNT, 32'd1);
    wr(OFS_CTRL, 32'h0b);
    // Each row runs as entry 0 against every device type
    foreach (rows[i])
      for (int d = 0; d < 6; d++)
      begin
        set_ent(8'd0, rows[i].cmd, d[2:0], 8'h1, rows[i].num, rows[i].pts);
        wr(OFS_EXEC, 32'h100);
        wt(1'b0, n_we + 1);
        chk({24'h0, status_err}, rows[i].mask[d] ? ERR_OK : ERR_CONFIG);
      end
    // Mid-run reset: outputs idle, registers back to reset values
    nrst <= 1'b0;
    repeat (6) @(posedge mclk);
    chk({req_valid, status_we, link_open, irq, hreadyout}, 32'h1);
    {n_req, n_open, n_close, n_we} = '0;
    nrst <= 1'b1;
    // Reset values, unmapped place, gap clamp
    rg(OFS_TIMEOUT, rd);
    chk(rd, {24'h0, TIMEOUT_RST_STEPS});
    rg(OFS_GAP, rd);
    chk(rd, {19'h0, GAP_RST_MS});
    rg(8'h3c, rd);
    chk(rd, 32'h0);
    chk({irq, hresp}, 32'h0);
    wr(OFS_GAP, 32'd6000);
    rg(OFS_GAP, rd);
    chk(rd, {19'h0, GAP_MAX_MS});
    wr(OFS_GAP, 32'd2);
    wr(OFS_TIMEOUT, 32'h0);
    wr(OFS_HOST, 32'h101);
    wr(OFS_HOST, 32'h102);
    wr(OFS_HOST, 32'h203);
    wr(OFS_COUNT, 32'd4);
    set_ent(8'd0, CMD_RD_WORD, DEV_DREG, 8'h1, 32'd10, 10'd1);
    set_ent(8'd1, CMD_WR_BIT, DEV_OUT, 8'h1, 32'h00ffffff, 10'd512);
    set_ent(8'd2, CMD_WR_WORD, DEV_RELAY, 8'h2, 32'd0, 10'd1);
    set_ent(8'd3, CMD_RD_BIT, DEV_IN, 8'h3, 32'd0, 10'd2);
    for (int i = 0; i < 4; i++)
      wr(OFS_EXEC, (i < 3) ? (32'h100 | i) : i);
    wr(OFS_IRQ_MASK, 32'h2);
    wr(OFS_CTRL, 32'h0b);
    // Normal pass over the table
    wt(1'b0, 3);
    repeat (600) @(posedge mclk);
    chk(n_req, 2);
    chk(n_we, 3);
    chk(cmd_q[0], CMD_RD_WORD);
    chk(cmd_q[1], CMD_WR_BIT);
    chk(we_q[0], {8'h00, ERR_OK, END_OK});
    chk(we_q[1], {8'h02, ERR_OK, END_OK});
    chk(we_q[2], {8'h04, ERR_CONFIG, END_CONFIG});
    chk({n_open, n_close}, {32'd1, 32'd0});
    chk(t_req[1] - t_we[0] >= 2 * CPM, 1);
    wr(OFS_TBL_IDX, 32'h0);
    rg(OFS_EXEC, rd);
    chk(rd & 32'h1, 32'h0);
    rg(OFS_IRQ_STAT, rd);
    chk(rd & 32'h7, 32'h7);
    chk(irq, 1'b1);
    wr(OFS_IRQ_STAT, 32'h2);
    @(negedge mclk);
    chk(irq, 1'b0);
    @(posedge mclk);
    // Silent far end: two resends then timeout
    pmode <= 2'd1;
    plat <= 4'h0;
    wr(OFS_EXEC, 32'h100);
    wt(1'b0, 4);
    chk(n_req, 5);
    chk((t_req[3] - t_req[2]) inside {[300 * CPM - 10 : 300 * CPM + 20]}, 1);
    chk((t_req[4] - t_req[3]) inside {[300 * CPM - 10 : 300 * CPM + 20]}, 1);
    chk(we_q[3], {8'h00, ERR_TIMEOUT, END_TIMEOUT});
    chk(irq, 1'b1);
    rg(OFS_EXEC, rd);
    chk(rd & 32'h1, 32'h0);
    wr(OFS_IRQ_STAT, 32'h2);
    @(negedge mclk);
    chk(irq, 1'b0);
    @(posedge mclk);
    // Slow abnormal reply
    pmode <= 2'd2;
    plat <= 4'h5;
    wr(OFS_EXEC, 32'h101);
    wt(1'b0, 5);
    chk(n_req, 6);
    chk(we_q[4], {8'h02, ERR_ABNORMAL, 16'h00c1});
    // Offline ping target held back, then host change with failure-only status
    pmode <= 2'd0;
    wr(OFS_CTRL, 32'h1f);
    wr(OFS_EXEC, 32'h103);
    repeat (600) @(posedge mclk);
    chk(n_req, 6);
    wr(OFS_HOST, 32'h303);
    wt(1'b1, 7);
    repeat (200) @(posedge mclk);
    chk(cmd_q[6], CMD_RD_BIT);
    chk({n_open, n_close}, {32'd2, 32'd1});
    chk(n_we, 5);
    test_done;
  end
endmodule
